// *** rtl/scc_map.vh ***
/*
 * register pointers, reset values and timing figures for the sensor conversion control.
 * assumes inclusion by bare name from files under rtl/.
 */
`ifndef SCC_MAP_VH
`define SCC_MAP_VH
// ==========================================================
// pointers
`define SCC_PTR_RATE_WR     8'h0a
`define SCC_PTR_RATE_RD     8'h04
`define SCC_PTR_TRIM        8'h18
`define SCC_PTR_SOFT_RESET  8'hfc
`define SCC_PTR_BETA_LOCAL  8'h25
`define SCC_PTR_BETA_REMOTE 8'h26
`define SCC_PTR_CHAN_EN     8'h1a
`define SCC_GC_RESET_BYTE   8'h06
// ==========================================================
// reset values
`define SCC_RATE_RST        8'h07
`define SCC_TRIM_RST        8'h00
`define SCC_BETA_RST        4'h8
`define SCC_CHAN_EN_RST     2'h3
// ==========================================================
// fields and codes
`define SCC_BETA_AUTO_BIT   3
`define SCC_BETA_DISABLED   4'h7
`define SCC_BETA_DIODE_RB   4'hf
`define SCC_RATE_FAST_CODE  8'h07
// ==========================================================
// timing in ms and base ideality in thousandths
`define SCC_T_CONV_LONG_MS  126
`define SCC_T_CONV_SHORT_MS 93
`define SCC_T_PERIOD_FAST_MS 125
`define SCC_IDEAL_DIODE     11'd1008
`define SCC_IDEAL_GND       11'd1000
`define SCC_TRIM_DENOM      10'd300
`endif

// *** rtl/scc_conversion_control.v ***
/*
 * conversion sequencing, rate, beta range and ideality trim control.
 * assumes a two-wire protocol engine on the same clock that presents decoded
 * register writes, reads and general-call bytes, and an analog front end that
 * reports the detected sensor type and beta range on request.
 */
// Function
// R1: rate register written at 0ah, read at 04h, resets to 07h; only idle time
// R2: codes 00h..06h give 1/16 to 4 conversions per second, doubling each step
// R3: codes 07h and above run at the fastest rate, eight per second
// R4: auto mode samples code each conversion, detects sensor type and range
// R5: code 0111 skips detection, measures as diode with no beta compensation
// R6: ideality 1.008 when disabled or diode, 1.000 when auto and grounded collector
// R7: auto reads back 1000..1111 for range, 126ms; diode reads 1111, 93ms
// R8: codes 0000..0110 select manual range with ideality 1.000, 93ms
// R9: trim register at 18h, signed -128..127, resets to 00h
// R10: effective ideality is base times 300 over 300 minus trim; code applies trim to the remote channel only, local denominator stays 300
// R11: write to fch resets registers, aborts conversion, releases alarms
// R12: general call followed by 06h resets; other second bytes ignored
// R13: sequence local, remote, shutdown, rate delay; disabled channels skipped
`default_nettype none
`include "scc_map.vh"
module scc_conversion_control #(
	parameter integer CLK_HZ          = 20000000,
	parameter integer T_CONV_LONG_CY  = (CLK_HZ / 1000) * `SCC_T_CONV_LONG_MS,
	parameter integer T_CONV_SHORT_CY = (CLK_HZ / 1000) * `SCC_T_CONV_SHORT_MS,
	parameter integer T_PERIOD_FAST_CY = (CLK_HZ / 1000) * `SCC_T_PERIOD_FAST_MS
) (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        wr_en_i,
	input  wire [7:0]  wr_ptr_i,
	input  wire [7:0]  wr_data_i,
	input  wire        rd_en_i,
	input  wire [7:0]  rd_ptr_i,
	output reg  [7:0]  rd_data_o,
	output reg         rd_hit_o,
	input  wire        gc_byte_en_i,
	input  wire [7:0]  gc_byte_i,
	input  wire        sensor_gnd_collector_i,
	input  wire [2:0]  sensor_beta_range_i,
	output reg         conv_busy_o,
	output reg         conv_remote_o,
	output reg         conv_start_o,
	output reg         conv_done_o,
	output reg         conv_abort_o,
	output reg         conv_auto_o,
	output reg  [2:0]  conv_beta_range_o,
	output reg  [10:0] base_ideality_o,
	output reg  [7:0]  ideality_trim_o,
	output reg  [10:0] ideal_numer_o,
	output reg  [9:0]  ideal_denom_o,
	output reg         alarm_release_o
);
// ==========================================================
// states
localparam [1:0] ST_IDLE  = 2'd0;
localparam [1:0] ST_LOCAL = 2'd1;
localparam [1:0] ST_REM   = 2'd2;
localparam [1:0] ST_WAIT  = 2'd3;
localparam [9:0] DENOM = `SCC_TRIM_DENOM;

reg  [7:0]  rate_q;
reg  [7:0]  trim_q;
reg  [3:0]  beta_local_q;
reg  [3:0]  beta_remote_q;
reg  [1:0]  chan_en_q;
reg  [1:0]  state_q;
reg  [31:0] cnt_q;
reg  [31:0] period_q;
reg  [3:0]  beta_rb_local_q;
reg  [3:0]  beta_rb_remote_q;
reg  [3:0]  code_s_q;
reg         gnd_q;
reg         range_ok_q;
wire        soft_rst;
reg  [2:0]  rate_eff;
reg  [31:0] rate_period;
reg  [31:0] conv_len;

assign soft_rst = (wr_en_i && wr_ptr_i == `SCC_PTR_SOFT_RESET) ||
	(gc_byte_en_i && gc_byte_i == `SCC_GC_RESET_BYTE); // [R11] [R12]

// ==========================================================
// rate decode: idle gap fills the period set by the code
always @* begin
	if (rate_q >= `SCC_RATE_FAST_CODE) begin
		rate_eff = 3'd7; // [R3]
	end else begin
		rate_eff = rate_q[2:0];
	end
	rate_period = T_PERIOD_FAST_CY << (3'd7 - rate_eff); // [R2]
end

// conversion length from code and detection; auto grounded is the long one
function [31:0] conv_cycles;
	input [3:0] code;
	input       gnd;
	begin
		if (code[`SCC_BETA_AUTO_BIT] && gnd) begin
			conv_cycles = T_CONV_LONG_CY; // [R7]
		end else begin
			conv_cycles = T_CONV_SHORT_CY; // [R7] [R8]
		end
	end
endfunction

function [10:0] base_ideal;
	input [3:0] code;
	input       gnd;
	begin
		if (code[`SCC_BETA_AUTO_BIT] && gnd) begin
			base_ideal = `SCC_IDEAL_GND; // [R6]
		end else if (code == `SCC_BETA_DISABLED || code[`SCC_BETA_AUTO_BIT]) begin
			base_ideal = `SCC_IDEAL_DIODE; // [R5] [R6]
		end else begin
			base_ideal = `SCC_IDEAL_GND; // [R8]
		end
	end
endfunction

always @* begin
	conv_len = conv_cycles(code_s_q, gnd_q);
end

// ==========================================================
// registers
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		rate_q        <= `SCC_RATE_RST;
		trim_q        <= `SCC_TRIM_RST;
		beta_local_q  <= `SCC_BETA_RST;
		beta_remote_q <= `SCC_BETA_RST;
		chan_en_q     <= `SCC_CHAN_EN_RST;
	end else if (soft_rst) begin
		rate_q        <= `SCC_RATE_RST; // [R11]
		trim_q        <= `SCC_TRIM_RST;
		beta_local_q  <= `SCC_BETA_RST;
		beta_remote_q <= `SCC_BETA_RST;
		chan_en_q     <= `SCC_CHAN_EN_RST;
	end else if (wr_en_i) begin
		case (wr_ptr_i)
			`SCC_PTR_RATE_WR: begin
				rate_q <= wr_data_i; // [R1]
			end
			`SCC_PTR_TRIM: begin
				trim_q <= wr_data_i; // [R9]
			end
			`SCC_PTR_BETA_LOCAL: begin
				beta_local_q <= wr_data_i[3:0];
			end
			`SCC_PTR_BETA_REMOTE: begin
				beta_remote_q <= wr_data_i[3:0];
			end
			`SCC_PTR_CHAN_EN: begin
				chan_en_q <= wr_data_i[1:0];
			end
			default: begin
				rate_q <= rate_q;
			end
		endcase
	end
end

// ==========================================================
// read port
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		rd_data_o <= 8'h00;
		rd_hit_o  <= 1'b0;
	end else begin
		rd_hit_o <= rd_en_i;
		if (rd_en_i) begin
			case (rd_ptr_i)
				`SCC_PTR_RATE_RD: begin
					rd_data_o <= rate_q; // [R1]
				end
				`SCC_PTR_TRIM: begin
					rd_data_o <= trim_q; // [R9]
				end
				`SCC_PTR_BETA_LOCAL: begin
					rd_data_o <= {4'h0, beta_rb_local_q};
				end
				`SCC_PTR_BETA_REMOTE: begin
					rd_data_o <= {4'h0, beta_rb_remote_q}; // [R7]
				end
				`SCC_PTR_CHAN_EN: begin
					rd_data_o <= {6'h00, chan_en_q};
				end
				default: begin
					rd_data_o <= 8'h00;
				end
			endcase
		end
	end
end

// ==========================================================
// conversion sequencer
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		state_q           <= ST_IDLE;
		cnt_q             <= 32'd0;
		period_q          <= 32'd0;
		code_s_q          <= `SCC_BETA_RST;
		gnd_q             <= 1'b0;
		range_ok_q        <= 1'b0;
		beta_rb_local_q   <= `SCC_BETA_RST;
		beta_rb_remote_q  <= `SCC_BETA_RST;
		conv_busy_o       <= 1'b0;
		conv_remote_o     <= 1'b0;
		conv_start_o      <= 1'b0;
		conv_done_o       <= 1'b0;
		conv_abort_o      <= 1'b0;
		conv_auto_o       <= 1'b0;
		conv_beta_range_o <= 3'd0;
		base_ideality_o   <= `SCC_IDEAL_DIODE;
		ideality_trim_o   <= 8'h00;
		ideal_numer_o     <= 11'd0;
		ideal_denom_o     <= DENOM;
		alarm_release_o   <= 1'b0;
	end else begin
		conv_start_o    <= 1'b0;
		conv_done_o     <= 1'b0;
		conv_abort_o    <= 1'b0;
		alarm_release_o <= 1'b0;
		period_q        <= period_q + 32'd1;
		if (soft_rst) begin
			conv_abort_o     <= conv_busy_o; // [R11]
			alarm_release_o  <= 1'b1;
			conv_busy_o      <= 1'b0;
			state_q          <= ST_IDLE;
			cnt_q            <= 32'd0;
			period_q         <= 32'd0;
			beta_rb_local_q  <= `SCC_BETA_RST;
			beta_rb_remote_q <= `SCC_BETA_RST;
		end else begin
			case (state_q)
				ST_IDLE: begin
					// pick the first enabled channel of the cycle
					period_q <= 32'd0;
					if (chan_en_q[0] || chan_en_q[1]) begin // [R13]
						state_q       <= chan_en_q[0] ? ST_LOCAL : ST_REM;
						conv_remote_o <= ~chan_en_q[0];
						code_s_q      <= chan_en_q[0] ? beta_local_q : beta_remote_q; // [R4]
						gnd_q         <= sensor_gnd_collector_i;
						range_ok_q    <= 1'b0;
						cnt_q         <= 32'd0;
						conv_start_o  <= 1'b1;
						conv_busy_o   <= 1'b1;
					end
				end
				ST_LOCAL, ST_REM: begin
					cnt_q <= cnt_q + 32'd1;
					if (!range_ok_q) begin
						// detection result one cycle after start
						range_ok_q <= 1'b1;
						gnd_q <= code_s_q[`SCC_BETA_AUTO_BIT] ?
							sensor_gnd_collector_i : 1'b0; // [R4] [R5]
						conv_auto_o <= code_s_q[`SCC_BETA_AUTO_BIT];
						conv_beta_range_o <= code_s_q[`SCC_BETA_AUTO_BIT] ?
							sensor_beta_range_i : code_s_q[2:0]; // [R8]
					end else if (cnt_q + 32'd1 >= conv_len) begin
						conv_done_o <= 1'b1;
						if (state_q == ST_LOCAL) begin
							beta_rb_local_q <= code_s_q[`SCC_BETA_AUTO_BIT] ?
								(gnd_q ? {1'b1, conv_beta_range_o} : `SCC_BETA_DIODE_RB)
								: code_s_q; // [R7]
						end else begin
							beta_rb_remote_q <= code_s_q[`SCC_BETA_AUTO_BIT] ?
								(gnd_q ? {1'b1, conv_beta_range_o} : `SCC_BETA_DIODE_RB)
								: code_s_q; // [R7]
						end
						if (state_q == ST_LOCAL && chan_en_q[1]) begin // [R13]
							state_q       <= ST_REM;
							conv_remote_o <= 1'b1;
							code_s_q      <= beta_remote_q; // [R4]
							range_ok_q    <= 1'b0;
							cnt_q         <= 32'd0;
							conv_start_o  <= 1'b1;
						end else begin
							state_q     <= ST_WAIT;
							conv_busy_o <= 1'b0;
						end
					end
					if (range_ok_q) begin
						base_ideality_o <= base_ideal(code_s_q, gnd_q); // [R6]
						ideality_trim_o <= state_q == ST_REM ? trim_q : 8'h00;
						ideal_numer_o   <= base_ideal(code_s_q, gnd_q);
						ideal_denom_o   <= state_q == ST_REM ?
							DENOM - {{2{trim_q[7]}}, trim_q} : DENOM; // [R10]
					end
				end
				ST_WAIT: begin
					// idle time only; conversion length is untouched by the rate
					// the idle state spends the last cycle of the period
					if (period_q + 32'd2 >= rate_period) begin // [R1] [R2]
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
end
endmodule
`default_nettype wire

// *** testbench/scc_conversion_monitor.sv ***
/* checker for the conversion control ports
   assumes binding to scc_conversion_control */
`default_nettype none
module scc_conversion_monitor (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        rd_en_i,
	input wire logic        rd_hit_o,
	input wire logic        wr_en_i,
	input wire logic [7:0]  wr_ptr_i,
	input wire logic        gc_byte_en_i,
	input wire logic [7:0]  gc_byte_i,
	input wire logic        alarm_release_o,
	input wire logic        conv_busy_o,
	input wire logic        conv_start_o,
	input wire logic        conv_abort_o,
	input wire logic        conv_done_o,
	input wire logic        conv_remote_o,
	input wire logic [10:0] base_ideality_o,
	input wire logic [7:0]  ideality_trim_o,
	input wire logic [10:0] ideal_numer_o,
	input wire logic [9:0]  ideal_denom_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	AST_RD_HIT: assert property (rd_en_i |=> rd_hit_o)
		else $error("read not answered");
	AST_FC_RESET: assert property (wr_en_i && wr_ptr_i == 8'hfc |=> alarm_release_o)
		else $error("pointer reset ignored");
	AST_GC_RESET: assert property (gc_byte_en_i && gc_byte_i == 8'h06 |=> alarm_release_o)
		else $error("general call reset ignored");
	AST_GC_IGNORE: assert property (gc_byte_en_i && gc_byte_i != 8'h06 && !wr_en_i
		|=> !alarm_release_o) else $error("other general call byte acted on");
	// a local done that hands over to the remote channel already shows the remote flag
	AST_LOCAL_DENOM: assert property (conv_done_o && (!conv_remote_o || conv_start_o)
		|-> ideal_denom_o == 10'd300) else $error("local channel trimmed");
	AST_REMOTE_DENOM: assert property (conv_done_o && conv_remote_o && !conv_start_o
		|-> ideal_numer_o == base_ideality_o
		&& ideal_denom_o == 10'd300 - {{2{ideality_trim_o[7]}}, ideality_trim_o})
		else $error("remote ideality wrong");
	AST_BASE: assert property (conv_done_o |-> base_ideality_o inside {11'd1000, 11'd1008})
		else $error("base ideality wrong");
	AST_CONV_MIN: assert property ($rose(conv_busy_o) |-> !conv_done_o [*8])
		else $error("conversion too short");
	AST_ABORT: assert property (conv_busy_o && (wr_en_i && wr_ptr_i == 8'hfc
		|| gc_byte_en_i && gc_byte_i == 8'h06) |=> conv_abort_o && !conv_busy_o)
		else $error("conversion not aborted");
endmodule
bind scc_conversion_control scc_conversion_monitor i_scc_conversion_monitor (
	.clock_i(clock_i), .rst_i(rst_i), .rd_en_i(rd_en_i), .rd_hit_o(rd_hit_o),
	.wr_en_i(wr_en_i), .wr_ptr_i(wr_ptr_i), .gc_byte_en_i(gc_byte_en_i),
	.gc_byte_i(gc_byte_i), .alarm_release_o(alarm_release_o), .conv_busy_o(conv_busy_o),
	.conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o), .conv_done_o(conv_done_o),
	.conv_remote_o(conv_remote_o), .base_ideality_o(base_ideality_o),
	.ideality_trim_o(ideality_trim_o), .ideal_numer_o(ideal_numer_o),
	.ideal_denom_o(ideal_denom_o));
`default_nettype wire

// *** testbench/scc_front_end_model.sv ***
/* analog front end model: reports detection results
   assumes the control samples them while a conversion is busy */
`default_nettype none
module scc_front_end_model (
	input wire logic        clock_i,
	input wire logic        busy_i,
	input wire logic        gnd_sel_i,
	input wire logic [2:0]  range_sel_i,
	output logic            gnd_o,
	output logic [2:0]      range_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic t_q = 1'b0;
	always @(posedge clock_i) t_q <= ~t_q;
	// outside a conversion the lines carry no valid result
	assign gnd_o = busy_i ? gnd_sel_i : t_q;
	assign range_o = busy_i ? range_sel_i : {3{t_q}};
endmodule
`default_nettype wire

// *** testbench/sensor_conversion_control_test.sv ***
/* self-checking bench for the conversion control
   assumes the checker and front end model are compiled first */
`default_nettype none
module sensor_conversion_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0, gc_byte_en_i = 1'b0;
	logic [7:0] wr_ptr_i = 8'h00, wr_data_i = 8'h00, rd_ptr_i = 8'h00, gc_byte_i = 8'h00;
	logic gsel = 1'b0;
	logic [2:0] rsel = 3'h0;
	wire gnd, busy, rem, start, done, hit;
	wire [2:0] rng;
	wire [7:0] rdat;
	wire [10:0] base;
	wire conv_auto;
	wire [2:0] brng;
	wire [9:0] den;
	int num_errors = 0, num_checks = 0, cycles = 0;
	always #25 clock_i = ~clock_i;
	scc_conversion_control #(.T_CONV_LONG_CY(40), .T_CONV_SHORT_CY(30), .T_PERIOD_FAST_CY(100))
	i_scc_conversion_control (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
		.wr_ptr_i(wr_ptr_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_ptr_i(rd_ptr_i),
		.rd_data_o(rdat), .rd_hit_o(hit), .gc_byte_en_i(gc_byte_en_i), .gc_byte_i(gc_byte_i),
		.sensor_gnd_collector_i(gnd), .sensor_beta_range_i(rng), .conv_busy_o(busy),
		.conv_remote_o(rem), .conv_start_o(start), .conv_done_o(done), .conv_abort_o(),
		.conv_auto_o(conv_auto), .conv_beta_range_o(brng), .base_ideality_o(base),
		.ideality_trim_o(), .ideal_numer_o(), .ideal_denom_o(den), .alarm_release_o());
	scc_front_end_model i_scc_front_end_model (.clock_i(clock_i), .busy_i(busy),
		.gnd_sel_i(gsel), .range_sel_i(rsel), .gnd_o(gnd), .range_o(rng));
	task automatic test_done;
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		wr_en_i <= 1'b1;
		wr_ptr_i <= p;
		wr_data_i <= d;
		@(posedge clock_i);
		wr_en_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		rd_en_i <= 1'b1;
		rd_ptr_i <= p;
		@(posedge clock_i);
		rd_en_i <= 1'b0;
		#1;
		chk(hit, 1'b1);
		chk(rdat, e);
		@(posedge clock_i);
	endtask
	task automatic gc(input logic [7:0] b);
		gc_byte_en_i <= 1'b1;
		gc_byte_i <= b;
		@(posedge clock_i);
		gc_byte_en_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic gap(input int exp);
		int n;
		repeat (2) do @(posedge clock_i); while (start !== 1'b1);
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (start !== 1'b1);
		chk(n, exp);
	endtask
	// ==========================================================
	// beta table: code, grounded, readback, base ideality; range fixed at 5
	logic [3:0] bc[4] = '{4'h8, 4'h8, 4'h7, 4'h3};
	logic bg[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	logic [3:0] bx[4] = '{4'hd, 4'hf, 4'h7, 4'h3};
	logic [10:0] bb[4] = '{11'd1000, 11'd1008, 11'd1008, 11'd1000};
	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(8'h04, 8'h07);
		rd(8'h18, 8'h00);
		rd(8'h77, 8'h00);
		wr(8'h04, 8'h01);
		rd(8'h04, 8'h07);
		wr(8'h18, 8'h80);
		rd(8'h18, 8'h80);
		for (int i = 0; i < 4; i++) begin
			gsel <= bg[i];
			rsel <= 3'h5;
			wr(8'h26, {4'h0, bc[i]});
			// the remote done is the one that starts no further conversion
			repeat (2) do @(posedge clock_i);
			while (!(done === 1'b1 && rem === 1'b1 && start === 1'b0));
			chk(base, bb[i]);
			chk(conv_auto, bc[i][3]);
			chk(brng, bc[i][3] ? 3'h5 : bc[i][2:0]);
			chk(den, 10'd428);
			rd(8'h26, {4'h0, bx[i]});
		end
		wr(8'h1a, 8'h01);
		for (int c = 4; c < 9; c++) begin
			wr(8'h0a, c[7:0]);
			gap(c > 6 ? 100 : 100 << (7 - c));
		end
		wr(8'hfc, 8'h5a);
		rd(8'h04, 8'h07);
		rd(8'h18, 8'h00);
		wr(8'h0a, 8'h05);
		gc(8'h05);
		rd(8'h04, 8'h05);
		gc(8'h06);
		rd(8'h04, 8'h07);
		test_done;
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			test_done;
		end
	end
endmodule
`default_nettype wire
